// >>> core/rci_pkg.sv
// package for the radio command and event-line block
// assumes a byte-wide host link delivering opcode and argument bytes
//
// Contract
// - decode configuration opcodes 0x00 to 0x02, 0x04 and 0x10 through 0x15
// - decode status opcodes 0x20 through 0x23
// - decode state opcodes 0x31 through 0x34
// - accept quick-read opcodes 0x50 51 53 57
// - 0x66 writes tx queue, 0x77 reads rx
// - bare transmit-start keeps previous argument values
// - condition byte: state, zero, resend, start
// - after transmit completes, enter encoded state if it is 1 to 9, else keep the current state
// - resend flag picks new or last packet
// - event line low on enabled pending events
// - line held low until status read
// - source needs own and group enable
// - all-status command returns the three pending bytes, no status bytes, and clears them all
// - group status clears only its group
// - instantaneous status follows the interrupt byte in group status replies only
// - quick reads never clear nor release line
// - direct-timing bit: 0 sync, 1 async
// - direct-pin field picks gpio 0 to 3
// - origin field: queue, pin, pseudo-random
// - modulation kind field: cw to four-level
package rci_pkg;
   localparam logic [7:0] OP_NOP      = 8'h00;
   localparam logic [7:0] OP_INFO     = 8'h01;
   localparam logic [7:0] OP_BOOT     = 8'h02;
   localparam logic [7:0] OP_PATCH    = 8'h04;
   localparam logic [7:0] OP_FUNC     = 8'h10;
   localparam logic [7:0] OP_SETPROP  = 8'h11;
   localparam logic [7:0] OP_GETPROP  = 8'h12;
   localparam logic [7:0] OP_PINCFG   = 8'h13;
   localparam logic [7:0] OP_SENSOR   = 8'h14;
   localparam logic [7:0] OP_QCLR     = 8'h15;
   localparam logic [7:0] OP_INTALL   = 8'h20;
   localparam logic [7:0] OP_INTPKT   = 8'h21;
   localparam logic [7:0] OP_INTDEM   = 8'h22;
   localparam logic [7:0] OP_INTDEV   = 8'h23;
   localparam logic [7:0] OP_TXSTART  = 8'h31;
   localparam logic [7:0] OP_RXSTART  = 8'h32;
   localparam logic [7:0] OP_STATEQ   = 8'h33;
   localparam logic [7:0] OP_CHSTATE  = 8'h34;
   localparam logic [7:0] OP_FASTA    = 8'h50;
   localparam logic [7:0] OP_FASTB    = 8'h51;
   localparam logic [7:0] OP_FASTC    = 8'h53;
   localparam logic [7:0] OP_FASTD    = 8'h57;
   localparam logic [7:0] OP_TXWR     = 8'h66;
   localparam logic [7:0] OP_RXRD     = 8'h77;
   localparam logic [7:0] CMD_DONE    = 8'hff;
   localparam logic [15:0] PROP_GRP_EN  = 16'h0100;
   localparam logic [15:0] PROP_PKT_EN  = 16'h0101;
   localparam logic [15:0] PROP_DEV_EN  = 16'h0102;
   localparam logic [15:0] PROP_DEM_EN  = 16'h0103;
   localparam logic [15:0] PROP_MOD     = 16'h2000;
   localparam logic [7:0]  MOD_RESET    = 8'h00;
   localparam logic [7:0]  EN_RESET     = 8'h00;
   localparam int GRP_PKT_BIT = 0;
   localparam int GRP_DEM_BIT = 1;
   localparam int GRP_DEV_BIT = 2;
   localparam int MOD_SYNC_BIT = 7;
   localparam int MOD_PIN_LSB  = 5;
   localparam int MOD_SRC_LSB  = 3;
   localparam int MOD_KIND_LSB = 0;
   localparam int COND_STATE_LSB = 4;
   localparam int COND_RESEND_BIT = 2;
   localparam int COND_START_LSB = 0;
   localparam int AFTER_STATE_MAX = 9;
   typedef enum logic [2:0] {
      RCI_IDLE, RCI_ARGS, RCI_REPLY, RCI_DRAIN
   } rci_state_t;
endpackage : rci_pkg

// >>> core/rci_core.sv
// radio command interpreter with grouped event line
// assumes bytes arrive as strobes from a serial framer on another clock
`timescale 1ns/1ns
`default_nettype none
module rci_core
   import rci_pkg::*;
(
   // clock and reset
   input  wire  logic       clock_in,
   input  wire  logic       rst_n_in,
   // host byte link, foreign domain: toggle strobe with data
   input  wire  logic       rx_toggle_in,
   input  wire  logic [7:0] rx_byte_in,
   input  wire  logic       frame_in,
   // event sources, one byte per group, pulses
   input  wire  logic [7:0] pkt_event_in,
   input  wire  logic [7:0] dem_event_in,
   input  wire  logic [7:0] dev_event_in,
   input  wire  logic [7:0] pkt_status_in,
   input  wire  logic [7:0] dem_status_in,
   input  wire  logic [7:0] dev_status_in,
   input  wire  logic       tx_done_in,
   // reply stream
   output logic             reply_valid_out,
   output logic [7:0]       reply_byte_out,
   // event line
   output logic             event_line_n_out,
   // decoded actions
   output logic             tx_go_out,
   output logic             rx_go_out,
   output logic             queue_clr_out,
   output logic             txq_wr_out,
   output logic             rxq_rd_out,
   output logic [7:0]       qdata_out,
   output logic [3:0]       radio_state_out,
   output logic [7:0]       channel_out,
   output logic             resend_flag_out,
   output logic [1:0]       start_cond_out,
   output logic [15:0]      tx_length_out,
   // modulation config fields
   output logic             direct_async_out,
   output logic [1:0]       direct_pin_out,
   output logic [1:0]       modulation_origin_out,
   output logic [2:0]       modulation_kind_out
);
   logic [2:0] tgl_q;
   logic [7:0] byte_s1_q, byte_q;
   logic       frm_s1_q, frm_q, frm_d1_q;
   logic       stb;
   always_ff @(posedge clock_in) begin
      tgl_q     <= {tgl_q[1:0], rx_toggle_in};
      byte_s1_q <= rx_byte_in;
      byte_q    <= byte_s1_q;
      frm_s1_q  <= frame_in;
      frm_q     <= frm_s1_q;
      frm_d1_q  <= frm_q;
   end
   assign stb = tgl_q[2] ^ tgl_q[1];
   rci_state_t st_q;
   logic [7:0] op_q;
   logic [2:0] idx_q;
   logic [7:0] chan_q, cond_q, mod_q, ge_q, pe_q, de_q, me_q;
   logic [15:0] len_q, paddr_q;
   logic [7:0] pkt_p_q, dem_p_q, dev_p_q;
   logic [3:0] rstate_q;
   logic [2:0] ridx_q, rlen_q;
   logic [7:0] rb [0:5];
   logic       frame_end;
   assign frame_end = frm_d1_q & ~frm_q;
   function automatic logic known_op(input logic [7:0] op);
      case (op)
         OP_NOP, OP_INFO, OP_BOOT, OP_PATCH, OP_FUNC, OP_SETPROP, OP_GETPROP,
         OP_PINCFG, OP_SENSOR, OP_QCLR, OP_INTALL, OP_INTPKT, OP_INTDEM,
         OP_INTDEV, OP_TXSTART, OP_RXSTART, OP_STATEQ, OP_CHSTATE, OP_FASTA,
         OP_FASTB, OP_FASTC, OP_FASTD, OP_TXWR, OP_RXRD: known_op = 1'b1;
         default: known_op = 1'b0;
      endcase
   endfunction : known_op

   function automatic logic [7:0] prop_rd(input logic [15:0] a, input logic [7:0] g,
         input logic [7:0] p, input logic [7:0] v, input logic [7:0] m, input logic [7:0] md);
      case (a)
         PROP_GRP_EN: prop_rd = g;
         PROP_PKT_EN: prop_rd = p;
         PROP_DEV_EN: prop_rd = v;
         PROP_DEM_EN: prop_rd = m;
         PROP_MOD:    prop_rd = md;
         default:     prop_rd = 8'h00;
      endcase
   endfunction : prop_rd
   // command sequencer
   logic clr_all, clr_pkt, clr_dem, clr_dev;
   logic reply_go;
   always_comb begin
      clr_all = 1'b0;
      clr_pkt = 1'b0;
      clr_dem = 1'b0;
      clr_dev = 1'b0;
      reply_go = (st_q == RCI_ARGS) && frame_end;
      if (reply_go) begin
         clr_all = (op_q == OP_INTALL);
         clr_pkt = (op_q == OP_INTPKT);
         clr_dem = (op_q == OP_INTDEM);
         clr_dev = (op_q == OP_INTDEV);
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         st_q <= RCI_IDLE;
         op_q <= OP_NOP;
         idx_q <= 3'h0;
         ridx_q <= 3'h0;
         rlen_q <= 3'h0;
         reply_valid_out <= 1'b0;
         reply_byte_out <= 8'h00;
         for (int i = 0; i < 6; i++) rb[i] <= 8'h00;
      end else begin
         reply_valid_out <= 1'b0;
         case (st_q)
            RCI_IDLE: begin
               if (stb) begin
                  op_q  <= byte_q;
                  idx_q <= 3'h0;
                  st_q  <= known_op(byte_q) ? RCI_ARGS : RCI_DRAIN;
               end
            end
            RCI_ARGS: begin
               if (stb && idx_q != 3'h7) idx_q <= idx_q + 3'h1;
               if (frame_end) begin
                  rb[0] <= CMD_DONE;
                  rb[1] <= 8'h00;
                  rb[2] <= 8'h00;
                  rb[3] <= 8'h00;
                  rb[4] <= 8'h00;
                  rb[5] <= 8'h00;
                  rlen_q <= 3'h1;
                  case (op_q)
                     OP_INTALL: begin
                        rb[1] <= pkt_p_q;
                        rb[2] <= dem_p_q;
                        rb[3] <= dev_p_q;
                        rlen_q <= 3'h4;
                     end
                     OP_INTPKT: begin
                        rb[1] <= pkt_p_q;
                        rb[2] <= pkt_status_in;
                        rlen_q <= 3'h3;
                     end
                     OP_INTDEM: begin
                        rb[1] <= dem_p_q;
                        rb[2] <= dem_status_in;
                        rlen_q <= 3'h3;
                     end
                     OP_INTDEV: begin
                        rb[1] <= dev_p_q;
                        rb[2] <= dev_status_in;
                        rlen_q <= 3'h3;
                     end
                     OP_FASTA, OP_FASTB, OP_FASTC, OP_FASTD: begin
                        rb[1] <= pkt_p_q;
                        rb[2] <= dem_p_q;
                        rb[3] <= dev_p_q;
                        rlen_q <= 3'h4;
                     end
                     OP_GETPROP: begin
                        rb[1] <= prop_rd(paddr_q, ge_q, pe_q, de_q, me_q, mod_q);
                        rlen_q <= 3'h2;
                     end
                     OP_STATEQ: begin
                        rb[1] <= {4'h0, rstate_q};
                        rlen_q <= 3'h2;
                     end
                     default: ;
                  endcase
                  ridx_q <= 3'h0;
                  st_q <= RCI_REPLY;
               end
            end
            RCI_REPLY: begin
               reply_valid_out <= 1'b1;
               reply_byte_out  <= rb[ridx_q];
               if (ridx_q == rlen_q - 3'h1) st_q <= RCI_IDLE;
               else ridx_q <= ridx_q + 3'h1;
            end
            RCI_DRAIN: begin
               if (frame_end) st_q <= RCI_IDLE;
            end
            default: st_q <= RCI_IDLE;
         endcase
      end
   end

   // argument capture
   logic argstb;
   assign argstb = (st_q == RCI_ARGS) && stb;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         chan_q <= 8'h00;
         cond_q <= 8'h00;
         len_q  <= 16'h0000;
         paddr_q <= 16'h0000;
      end else if (argstb && (op_q == OP_TXSTART)) begin
         case (idx_q)
            3'h0: chan_q <= byte_q;
            3'h1: cond_q <= {byte_q[7:4], 1'b0, byte_q[2:0]};
            3'h2: len_q[15:8] <= byte_q;
            3'h3: len_q[7:0] <= byte_q;
            default: ;
         endcase
      end else if (argstb && (op_q == OP_SETPROP || op_q == OP_GETPROP)) begin
         if (idx_q == 3'h0) paddr_q[15:8] <= byte_q;
         if (idx_q == 3'h1) paddr_q[7:0] <= byte_q;
      end
   end

   // property store
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ge_q <= EN_RESET;
         pe_q <= EN_RESET;
         de_q <= EN_RESET;
         me_q <= EN_RESET;
         mod_q <= MOD_RESET;
      end else if (argstb && op_q == OP_SETPROP && idx_q == 3'h2) begin
         case (paddr_q)
            PROP_GRP_EN: ge_q <= byte_q;
            PROP_PKT_EN: pe_q <= byte_q;
            PROP_DEV_EN: de_q <= byte_q;
            PROP_DEM_EN: me_q <= byte_q;
            PROP_MOD:    mod_q <= byte_q;
            default: ;
         endcase
      end
   end

   // pending events, set wins over clear
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         pkt_p_q <= 8'h00;
         dem_p_q <= 8'h00;
         dev_p_q <= 8'h00;
      end else begin
         pkt_p_q <= (clr_all | clr_pkt ? 8'h00 : pkt_p_q) | pkt_event_in;
         dem_p_q <= (clr_all | clr_dem ? 8'h00 : dem_p_q) | dem_event_in;
         dev_p_q <= (clr_all | clr_dev ? 8'h00 : dev_p_q) | dev_event_in;
      end
   end

   // event line
   logic any_en;
   assign any_en = (ge_q[GRP_PKT_BIT] && |(pkt_p_q & pe_q))
                || (ge_q[GRP_DEM_BIT] && |(dem_p_q & me_q))
                || (ge_q[GRP_DEV_BIT] && |(dev_p_q & de_q));
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) event_line_n_out <= 1'b1;
      else event_line_n_out <= ~any_en;
   end

   // actions and radio state
   logic [3:0] nxt;
   assign nxt = cond_q[7:COND_STATE_LSB];
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         tx_go_out <= 1'b0;
         rx_go_out <= 1'b0;
         queue_clr_out <= 1'b0;
         txq_wr_out <= 1'b0;
         rxq_rd_out <= 1'b0;
         qdata_out <= 8'h00;
         rstate_q <= 4'h3;
      end else begin
         tx_go_out <= reply_go && op_q == OP_TXSTART;
         rx_go_out <= reply_go && op_q == OP_RXSTART;
         queue_clr_out <= reply_go && op_q == OP_QCLR;
         txq_wr_out <= argstb && op_q == OP_TXWR;
         rxq_rd_out <= argstb && op_q == OP_RXRD;
         qdata_out <= byte_q;
         if (reply_go && op_q == OP_TXSTART) rstate_q <= 4'h5;
         else if (reply_go && op_q == OP_RXSTART) rstate_q <= 4'h6;
         else if (argstb && op_q == OP_CHSTATE && idx_q == 3'h0) rstate_q <= byte_q[3:0];
         else if (tx_done_in && nxt != 4'h0 && nxt <= 4'(AFTER_STATE_MAX))
            rstate_q <= nxt;
      end
   end
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         radio_state_out <= 4'h3;
         channel_out <= 8'h00;
         resend_flag_out <= 1'b0;
         start_cond_out <= 2'h0;
         tx_length_out <= 16'h0000;
         direct_async_out <= 1'b0;
         direct_pin_out <= 2'h0;
         modulation_origin_out <= 2'h0;
         modulation_kind_out <= 3'h0;
      end else begin
         radio_state_out <= rstate_q;
         channel_out <= chan_q;
         resend_flag_out <= cond_q[COND_RESEND_BIT];
         start_cond_out <= cond_q[COND_START_LSB +: 2];
         tx_length_out <= len_q;
         direct_async_out <= mod_q[MOD_SYNC_BIT];
         direct_pin_out <= mod_q[MOD_PIN_LSB +: 2];
         modulation_origin_out <= mod_q[MOD_SRC_LSB +: 2];
         modulation_kind_out <= mod_q[MOD_KIND_LSB +: 3];
      end
   end
   property p_line_low;
      @(posedge clock_in) disable iff (!rst_n_in) any_en |=> !event_line_n_out;
   endproperty
   a_line_low: assert property (p_line_low) else $error("line not low");
   property p_clr_all;
      @(posedge clock_in) disable iff (!rst_n_in)
         clr_all && !$past(clr_all) |=> (pkt_p_q == $past(pkt_event_in));
   endproperty
   a_clr_all: assert property (p_clr_all) else $error("all clear failed");
   property p_fast;
      @(posedge clock_in) disable iff (!rst_n_in)
         reply_go && op_q == OP_FASTA |-> !clr_all && !clr_pkt && !clr_dem && !clr_dev;
   endproperty
   a_fast: assert property (p_fast) else $error("quick read cleared");
   property p_done;
      @(posedge clock_in) disable iff (!rst_n_in)
         reply_go |-> ##2 reply_valid_out && reply_byte_out == CMD_DONE;
   endproperty
   a_done: assert property (p_done) else $error("no completion byte");
   property p_grp_only;
      @(posedge clock_in) disable iff (!rst_n_in)
         clr_pkt |=> dem_p_q == ($past(dem_p_q) | $past(dem_event_in));
   endproperty
   a_grp_only: assert property (p_grp_only) else $error("group clear spread");
   property p_line_high;
      @(posedge clock_in) disable iff (!rst_n_in) !any_en |=> event_line_n_out;
   endproperty
   a_line_high: assert property (p_line_high) else $error("line not released");
endmodule : rci_core
`default_nettype wire

// >>> verification/rci_host_model.sv
// host model: sends command frames as toggled bytes, one per 400 ns link clock
// assumes the block samples the toggle with its own clock and reads the byte later
`timescale 1ns/1ns
`default_nettype none
module rci_host_model (
   // byte link towards the block
   output logic       toggle_out,
   output logic [7:0] byte_out,
   output logic       frame_out
);
   initial begin
      toggle_out = 1'b0;
      byte_out   = 8'h00;
      frame_out  = 1'b0;
   end
   // opcode first, then the arguments in order; a bare opcode is a legal frame
   task automatic send(input logic [7:0] b [$]);
      frame_out = 1'b1;
      foreach (b[i]) begin
         #200 byte_out = b[i];
         #200 toggle_out = ~toggle_out;
      end
      #400 frame_out = 1'b0;
      byte_out = ~byte_out;
   endtask : send
endmodule : rci_host_model
`default_nettype wire

// >>> verification/rci_core_tb_top.sv
// testbench for the command interpreter: frames from the host model, checks replies
// assumes the block answers each accepted frame with a done byte and its data
`timescale 1ns/1ns
`default_nettype none
module rci_core_tb_top;
   import rci_pkg::*;
   logic        clock_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        rx_toggle_in, frame_in, tx_done_in = 1'b0;
   logic [7:0]  rx_byte_in;
   logic [7:0]  pkt_event_in = 8'h00, dem_event_in = 8'h00, dev_event_in = 8'h00;
   logic [7:0]  pkt_status_in = 8'h00, dem_status_in = 8'h00, dev_status_in = 8'h00;
   logic        reply_valid_out, event_line_n_out, tx_go_out, rx_go_out, queue_clr_out;
   logic        txq_wr_out, rxq_rd_out, resend_flag_out, direct_async_out;
   logic [7:0]  reply_byte_out, channel_out, qdata_out;
   logic [3:0]  radio_state_out;
   logic [1:0]  start_cond_out, direct_pin_out, modulation_origin_out;
   logic [15:0] tx_length_out;
   logic [2:0]  modulation_kind_out;
   logic [7:0]  rq [$];
   logic [7:0]  wq [$];
   logic [7:0]  ops [$];
   int          errors = 0, checks = 0, n_tx = 0, n_rx = 0, n_clr = 0, n_wr = 0, n_rd = 0;

   rci_core rci_core_i (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .rx_toggle_in(rx_toggle_in),
      .rx_byte_in(rx_byte_in), .frame_in(frame_in), .pkt_event_in(pkt_event_in),
      .dem_event_in(dem_event_in), .dev_event_in(dev_event_in),
      .pkt_status_in(pkt_status_in), .dem_status_in(dem_status_in),
      .dev_status_in(dev_status_in), .tx_done_in(tx_done_in),
      .reply_valid_out(reply_valid_out), .reply_byte_out(reply_byte_out),
      .event_line_n_out(event_line_n_out), .tx_go_out(tx_go_out), .rx_go_out(rx_go_out),
      .queue_clr_out(queue_clr_out), .txq_wr_out(txq_wr_out), .rxq_rd_out(rxq_rd_out),
      .qdata_out(qdata_out), .radio_state_out(radio_state_out), .channel_out(channel_out),
      .resend_flag_out(resend_flag_out), .start_cond_out(start_cond_out),
      .tx_length_out(tx_length_out), .direct_async_out(direct_async_out),
      .direct_pin_out(direct_pin_out), .modulation_origin_out(modulation_origin_out),
      .modulation_kind_out(modulation_kind_out));
   rci_host_model rci_host_model_i (.toggle_out(rx_toggle_in), .byte_out(rx_byte_in),
                                    .frame_out(frame_in));

   always #25 clock_in = ~clock_in;

   always @(posedge clock_in) begin
      if (reply_valid_out === 1'b1) rq.push_back(reply_byte_out);
      if (tx_go_out === 1'b1) n_tx++;
      if (rx_go_out === 1'b1) n_rx++;
      if (queue_clr_out === 1'b1) n_clr++;
      if (rxq_rd_out === 1'b1) n_rd++;
      if (txq_wr_out === 1'b1) begin
         n_wr++;
         wq.push_back(qdata_out);
      end
   end

   task automatic wrap_up;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic int reply_len(input logic [7:0] op);
      case (op)
         OP_INTALL, OP_FASTA, OP_FASTB, OP_FASTC, OP_FASTD: return 4;
         OP_INTPKT, OP_INTDEM, OP_INTDEV: return 3;
         OP_STATEQ, OP_GETPROP: return 2;
         OP_NOP, OP_INFO, OP_BOOT, OP_PATCH, OP_FUNC, OP_SETPROP, OP_PINCFG, OP_SENSOR,
         OP_QCLR, OP_TXSTART, OP_RXSTART, OP_CHSTATE, OP_TXWR, OP_RXRD: return 1;
         default: return 0;
      endcase
   endfunction : reply_len

   // one frame, then a bounded wait for the whole reply
   task automatic cmd(input logic [7:0] b [$]);
      int nr;
      nr = reply_len(b[0]);
      rq.delete();
      rci_host_model_i.send(b);
      for (int k = 0; k < 40 && rq.size() < nr; k++) @(negedge clock_in);
      repeat (10) @(negedge clock_in);
      chk(16'(rq.size()), 16'(nr));
      if (rq.size() != nr) wrap_up();
      if (nr > 0) chk(rq[0], CMD_DONE);
   endtask : cmd

   task automatic ev(input logic [7:0] p, input logic [7:0] d, input logic [7:0] e);
      pkt_event_in = p;
      dem_event_in = d;
      dev_event_in = e;
      @(negedge clock_in);
      pkt_event_in = 8'h00;
      dem_event_in = 8'h00;
      dev_event_in = 8'h00;
      repeat (3) @(negedge clock_in);
   endtask : ev

   initial begin
      logic [7:0] v, m;
      void'($urandom(32'h15dcff58));
      repeat (20) @(negedge clock_in);
      rst_n_in = 1'b1;
      @(negedge clock_in);
      chk(event_line_n_out, 1'b1);
      chk(radio_state_out, 4'h3);
      chk({direct_async_out, direct_pin_out, modulation_origin_out, modulation_kind_out},
          MOD_RESET);
      // modulation property written and read back, every field decoded
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hff : 8'($urandom);
         cmd({OP_SETPROP, 8'h20, 8'h00, v});
         cmd({OP_GETPROP, 8'h20, 8'h00});
         chk(rq[1], v);
         chk(direct_async_out, v[7]);
         chk(direct_pin_out, v[6:5]);
         chk(modulation_origin_out, v[4:3]);
         chk(modulation_kind_out, v[2:0]);
      end
      // every opcode alone except OP_SETPROP, OP_GETPROP, OP_TXSTART, OP_CHSTATE and OP_TXWR, plus two unknown ones that must be ignored
      ops = {OP_NOP, OP_INFO, OP_BOOT, OP_PATCH, OP_FUNC, OP_PINCFG, OP_SENSOR, OP_QCLR,
             OP_INTALL, OP_INTPKT, OP_INTDEM, OP_INTDEV, OP_RXSTART, OP_STATEQ, OP_FASTA,
             OP_FASTB, OP_FASTC, OP_FASTD, OP_RXRD, 8'h99, 8'h3f};
      foreach (ops[i]) cmd({ops[i]});
      chk(16'(n_clr), 16'h1);
      chk(16'(n_rx), 16'h1);
      cmd({OP_STATEQ});
      chk(rq[1], 8'h06);
      chk(radio_state_out, 4'h6);
      cmd({OP_CHSTATE, 8'h04});
      chk(radio_state_out, 4'h4);
      cmd({OP_RXRD, 8'h02, 8'h03});
      chk(16'(n_rd), 16'h2);
      // transmit start with full arguments, then bare and partial
      v = {4'(1 + $urandom % AFTER_STATE_MAX), 1'b0, 1'($urandom), 2'($urandom)};
      m = 8'($urandom);
      cmd({OP_TXSTART, m, v, 8'h12, 8'h34});
      chk(channel_out, m);
      chk(resend_flag_out, v[2]);
      chk(start_cond_out, v[1:0]);
      chk(tx_length_out, 16'h1234);
      cmd({OP_TXSTART});
      chk(channel_out, m);
      chk(tx_length_out, 16'h1234);
      tx_done_in = 1'b1;
      @(negedge clock_in);
      tx_done_in = 1'b0;
      repeat (3) @(negedge clock_in);
      chk(radio_state_out, v[7:4]);
      cmd({OP_TXSTART, 8'h00, 8'h04});
      chk(channel_out, 8'h00);
      chk(resend_flag_out, 1'b1);
      chk(start_cond_out, 2'h0);
      chk(tx_length_out, 16'h1234);
      tx_done_in = 1'b1;
      @(negedge clock_in);
      tx_done_in = 1'b0;
      repeat (3) @(negedge clock_in);
      chk(radio_state_out, 4'h5);
      chk(16'(n_tx), 16'h3);
      v = 8'($urandom);
      m = 8'($urandom);
      cmd({OP_TXWR, v, m, 8'h5a});
      chk(16'(n_wr), 16'h3);
      chk({wq[0], wq[1]}, {v, m});
      chk(wq[2], 8'h5a);
      // event line: enables, quick reads, group and full clears
      m = 8'($urandom) | 8'h01;
      cmd({OP_SETPROP, 8'h01, 8'h00, 8'h07});
      cmd({OP_SETPROP, 8'h01, 8'h01, m});
      cmd({OP_SETPROP, 8'h01, 8'h03, 8'hff});
      ev(~m, 8'h00, 8'h00);
      chk(event_line_n_out, 1'b1);
      cmd({OP_INTALL});
      ev(8'h01, 8'h80, 8'h00);
      chk(event_line_n_out, 1'b0);
      cmd({OP_FASTB});
      chk(rq[1], 8'h01);
      chk(rq[2], 8'h80);
      chk(event_line_n_out, 1'b0);
      pkt_status_in = 8'($urandom);
      cmd({OP_INTPKT});
      chk(rq[1], 8'h01);
      chk(rq[2], pkt_status_in);
      chk(event_line_n_out, 1'b0);
      cmd({OP_INTDEM});
      chk(rq[1], 8'h80);
      chk(event_line_n_out, 1'b1);
      cmd({OP_SETPROP, 8'h01, 8'h00, 8'h05});
      ev(8'h00, 8'h01, 8'h00);
      chk(event_line_n_out, 1'b1);
      ev(8'h01, 8'h00, 8'h00);
      cmd({OP_INTALL});
      chk(rq[1], 8'h01);
      cmd({OP_INTALL});
      chk({rq[1], rq[2]}, 16'h0000);
      chk(event_line_n_out, 1'b1);
      // device group: one enabled and one masked source, then its own clear
      dev_status_in = 8'($urandom);
      cmd({OP_SETPROP, 8'h01, 8'h02, 8'h10});
      ev(8'h00, 8'h00, 8'h30);
      chk(event_line_n_out, 1'b0);
      cmd({OP_INTDEV});
      chk(rq[1], 8'h30);
      chk(rq[2], dev_status_in);
      chk(event_line_n_out, 1'b1);
      wrap_up();
   end
endmodule : rci_core_tb_top
`default_nettype wire
